// ===== rtl/vts_timers_shifter.sv
// Interval timers, serial shift-in register and interrupt flagging behind a Wishbone slave
`default_nettype none
`include "vts_regs.svh"
module vts_timers_shifter (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:2] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Port B pins used by the timers
   input wire logic pulse_count_pin_i,
   output logic timer_output_pin_o,
   output logic timer_output_pin_oe_o,
   // Serial pins
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   input wire logic serial_data_pin_i,
   output logic serial_data_pin_o,
   output logic serial_data_pin_oe_o,
   // Open-collector interrupt request
   output logic irq_n_o,
   output logic irq_n_oe_o
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic ack_reg;
   logic [31:0] dat_reg;
   vts_pkg::vts_byte_t port_b_output_reg, port_b_direction_reg;
   vts_pkg::vts_byte_t auxiliary_control_reg, peripheral_control_reg;
   vts_pkg::vts_byte_t serial_shifter_reg, timer_two_latch_low_reg;
   logic [15:0] t1_cnt_reg, t1_latch_reg, t2_cnt_reg;
   logic t1_armed_reg, t1_out_reg, t2_armed_reg;
   logic [6:0] ifr_reg, ier_reg;
   logic [2:0] pc_sync_reg, ck_sync_reg;
   logic [1:0] sd_sync_reg;
   vts_pkg::vts_shift_state_t sh_state_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] pace_reg;
   logic sclk_reg, sample_reg, sample_d_reg;
   logic [3:0] rises_reg;
   logic pin7_reg, pin7_oe_reg, sck_oe_reg, sd_reg, sd_oe_reg, irq_oe_reg;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Side effects fire once, in the cycle the answer is raised
   wire access = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire wr = access & wb_we_i & wb_sel_i[0];
   wire rd = access & ~wb_we_i;
   wire [7:0] d = wb_dat_i[7:0];
   wire [3:0] idx = wb_adr_i[5:2];
   wire wr_t1cl = wr && (idx == `VTS_IDX_T1_COUNT_LOW);
   wire wr_t1ch = wr && (idx == `VTS_IDX_T1_COUNT_HIGH);
   wire wr_t1ll = wr && (idx == `VTS_IDX_T1_LATCH_LOW);
   wire wr_t1lh = wr && (idx == `VTS_IDX_T1_LATCH_HIGH);
   wire rd_t1cl = rd && (idx == `VTS_IDX_T1_COUNT_LOW);
   wire wr_t2cl = wr && (idx == `VTS_IDX_T2_COUNT_LOW);
   wire wr_t2ch = wr && (idx == `VTS_IDX_T2_COUNT_HIGH);
   wire rd_t2cl = rd && (idx == `VTS_IDX_T2_COUNT_LOW);
   wire sr_touch = (rd | wr) && (idx == `VTS_IDX_SERIAL_SHIFTER);
   wire wr_sr = wr && (idx == `VTS_IDX_SERIAL_SHIFTER);
   wire wr_ifr = wr && (idx == `VTS_IDX_INT_FLAGS);
   wire wr_ier = wr && (idx == `VTS_IDX_INT_ENABLES);

   // ----------------------------------------------------------------
   // Mode selection
   // ----------------------------------------------------------------
   wire t1_free = auxiliary_control_reg[`VTS_ACR_T1_FREE_RUN];
   wire t2_pulse = auxiliary_control_reg[`VTS_ACR_T2_PULSE];
   wire [2:0] sr_mode = auxiliary_control_reg[`VTS_ACR_SR_MSB:`VTS_ACR_SR_LSB];
   wire mode_t2 = (sr_mode == `VTS_SR_IN_T2);
   wire mode_sys = (sr_mode == `VTS_SR_IN_SYS);
   wire mode_ext = (sr_mode == `VTS_SR_IN_EXT);
   wire mode_int = mode_t2 | mode_sys;
   wire pin7_timer = port_b_direction_reg[7] & auxiliary_control_reg[`VTS_ACR_T1_OUT_EN];

   // ----------------------------------------------------------------
   // First timer
   // ----------------------------------------------------------------
   // A load in the same cycle masks the zero so a rewrite always wins
   wire t1_timeout = (t1_cnt_reg == 16'h0000) & ~wr_t1ch;
   wire t1_set = t1_timeout & (t1_armed_reg | t1_free);
   wire [15:0] t1_reload = {d, t1_latch_reg[7:0]};

   // Counter: latch-only writes never touch it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1_cnt_reg <= `VTS_RST_WORD;
      end else if (wr_t1ch) begin
         t1_cnt_reg <= t1_reload;
      end else if (t1_timeout && t1_free) begin
         t1_cnt_reg <= t1_latch_reg;
      end else begin
         t1_cnt_reg <= t1_cnt_reg - 16'h0001;
      end
   end

   // Latches: count-low writes go to the low latch as well
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1_latch_reg <= `VTS_RST_WORD;
      end else if (wr_t1cl || wr_t1ll) begin
         t1_latch_reg[7:0] <= d;
      end else if (wr_t1ch || wr_t1lh) begin
         t1_latch_reg[15:8] <= d;
      end
   end

   // Arming and output level; a load starts the output low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1_armed_reg <= 1'b0;
         t1_out_reg <= 1'b1;
      end else if (wr_t1ch) begin
         t1_armed_reg <= 1'b1;
         t1_out_reg <= 1'b0;
      end else if (t1_set) begin
         t1_armed_reg <= 1'b0;
         t1_out_reg <= ~t1_out_reg;
      end
   end

   // ----------------------------------------------------------------
   // Second timer
   // ----------------------------------------------------------------
   // Pulse input is sampled twice before the edge detector sees it
   wire pc_fall = pc_sync_reg[2] & ~pc_sync_reg[1];
   wire t2_dec = t2_pulse ? pc_fall : 1'b1;
   wire t2_timeout = (t2_cnt_reg == 16'h0000) & t2_dec & ~wr_t2ch;
   wire t2_set = t2_timeout & t2_armed_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_sync_reg <= 3'h7;
      end else begin
         pc_sync_reg <= {pc_sync_reg[1:0], pulse_count_pin_i};
      end
   end

   // Counter keeps running through zero; only the flag is one-shot
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t2_cnt_reg <= `VTS_RST_WORD;
         t2_armed_reg <= 1'b0;
      end else if (wr_t2ch) begin
         t2_cnt_reg <= {d, timer_two_latch_low_reg};
         t2_armed_reg <= 1'b1;
      end else begin
         if (t2_dec) begin
            t2_cnt_reg <= t2_cnt_reg - 16'h0001;
         end
         if (t2_set) begin
            t2_armed_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_two_latch_low_reg <= `VTS_RST_BYTE;
      end else if (wr_t2cl) begin
         timer_two_latch_low_reg <= d;
      end
   end

   // ----------------------------------------------------------------
   // Serial shifter
   // ----------------------------------------------------------------
   // Pace tick: every cycle at system rate, every latch+1 under timer two;
   // it stops after the eighth rise so the clock rests high between frames
   wire pace_tick = (sh_state_reg == vts_pkg::SH_RUN) & ~rises_reg[3] &
      (mode_sys | (pace_reg == 8'h00));
   wire ext_rise = ck_sync_reg[1] & ~ck_sync_reg[2];
   wire shift_en = mode_int ? sample_d_reg : (mode_ext & ext_rise);
   wire last_bit = shift_en & (bit_cnt_reg == 3'h7);
   wire sr_set = last_bit & ~sr_touch;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ck_sync_reg <= 3'h7;
         sd_sync_reg <= 2'h0;
      end else begin
         ck_sync_reg <= {ck_sync_reg[1:0], serial_clock_pin_i};
         sd_sync_reg <= {sd_sync_reg[0], serial_data_pin_i};
      end
   end

   // Data word: processor writes win over a shift in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_shifter_reg <= `VTS_RST_BYTE;
      end else if (wr_sr) begin
         serial_shifter_reg <= d;
      end else if (shift_en) begin
         serial_shifter_reg <= {serial_shifter_reg[6:0], sd_sync_reg[1]};
      end
   end

   // Bit counter and run state; an access restarts the eight-bit count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_cnt_reg <= 3'h0;
         sh_state_reg <= vts_pkg::SH_IDLE;
      end else if (sr_touch) begin
         bit_cnt_reg <= 3'h0;
         sh_state_reg <= mode_int ? vts_pkg::SH_RUN : vts_pkg::SH_IDLE;
      end else if (!mode_int) begin
         sh_state_reg <= vts_pkg::SH_IDLE;
         if (shift_en) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
         end
      end else if (shift_en) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (last_bit) begin
            sh_state_reg <= vts_pkg::SH_IDLE;
         end
      end
   end

   // Output clock idles high; data is taken two cycles after it rises
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_reg <= 1'b1;
         sample_reg <= 1'b0;
         sample_d_reg <= 1'b0;
         rises_reg <= 4'h0;
         pace_reg <= `VTS_RST_BYTE;
      end else if (sr_touch) begin
         sclk_reg <= 1'b1;
         sample_reg <= 1'b0;
         sample_d_reg <= 1'b0;
         rises_reg <= 4'h0;
         pace_reg <= timer_two_latch_low_reg;
      end else begin
         sample_reg <= pace_tick & ~sclk_reg;
         // Data pin is two flops behind the clock we drive, so take it a cycle later
         sample_d_reg <= sample_reg;
         if (pace_tick) begin
            sclk_reg <= ~sclk_reg;
            pace_reg <= timer_two_latch_low_reg;
            if (!sclk_reg) rises_reg <= rises_reg + 4'h1;
         end else if (sh_state_reg == vts_pkg::SH_RUN) begin
            pace_reg <= pace_reg - 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt flags and enables
   // ----------------------------------------------------------------
   // Hardware sets win over flag writes and count-low reads in the same cycle; count-high writes and shifter accesses block the set
   wire t1_clr = wr_t1ch | rd_t1cl | (wr_ifr & d[`VTS_IFR_T1]);
   wire t2_clr = wr_t2ch | rd_t2cl | (wr_ifr & d[`VTS_IFR_T2]);
   wire sr_clr = sr_touch | (wr_ifr & d[`VTS_IFR_SR]);
   wire irq_any = |(ifr_reg & ier_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ifr_reg <= 7'h00;
      end else begin
         ifr_reg[`VTS_IFR_T1] <= (ifr_reg[`VTS_IFR_T1] & ~t1_clr) | t1_set;
         ifr_reg[`VTS_IFR_T2] <= (ifr_reg[`VTS_IFR_T2] & ~t2_clr) | t2_set;
         ifr_reg[`VTS_IFR_SR] <= (sr_mode != `VTS_SR_OFF) &
            ((ifr_reg[`VTS_IFR_SR] & ~sr_clr) | sr_set);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ier_reg <= 7'h00;
      end else if (wr_ier) begin
         ier_reg <= d[`VTS_IER_SET] ? (ier_reg | d[6:0]) : (ier_reg & ~d[6:0]);
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_b_output_reg <= `VTS_RST_BYTE;
         port_b_direction_reg <= `VTS_RST_BYTE;
         auxiliary_control_reg <= `VTS_RST_BYTE;
         peripheral_control_reg <= `VTS_RST_BYTE;
      end else if (wr) begin
         if (idx == `VTS_IDX_PORT_B_OUTPUT) port_b_output_reg <= d;
         if (idx == `VTS_IDX_PORT_B_DIRECTION) port_b_direction_reg <= d;
         if (idx == `VTS_IDX_AUX_CONTROL) auxiliary_control_reg <= d;
         if (idx == `VTS_IDX_PERIPH_CONTROL) peripheral_control_reg <= d;
      end
   end

   // ----------------------------------------------------------------
   // Read mux and bus answer
   // ----------------------------------------------------------------
   // Unmapped indices read as zero and are still acknowledged
   logic [7:0] rd_byte;
   always_comb begin
      unique case (idx)
         `VTS_IDX_PORT_B_OUTPUT: rd_byte = port_b_output_reg;
         `VTS_IDX_PORT_B_DIRECTION: rd_byte = port_b_direction_reg;
         `VTS_IDX_T1_COUNT_LOW: rd_byte = t1_cnt_reg[7:0];
         `VTS_IDX_T1_COUNT_HIGH: rd_byte = t1_cnt_reg[15:8];
         `VTS_IDX_T1_LATCH_LOW: rd_byte = t1_latch_reg[7:0];
         `VTS_IDX_T1_LATCH_HIGH: rd_byte = t1_latch_reg[15:8];
         `VTS_IDX_T2_COUNT_LOW: rd_byte = t2_cnt_reg[7:0];
         `VTS_IDX_T2_COUNT_HIGH: rd_byte = t2_cnt_reg[15:8];
         `VTS_IDX_SERIAL_SHIFTER: rd_byte = serial_shifter_reg;
         `VTS_IDX_AUX_CONTROL: rd_byte = auxiliary_control_reg;
         `VTS_IDX_PERIPH_CONTROL: rd_byte = peripheral_control_reg;
         `VTS_IDX_INT_FLAGS: rd_byte = {irq_any, ifr_reg};
         `VTS_IDX_INT_ENABLES: rd_byte = {1'b0, ier_reg};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= access;
         dat_reg <= (access & ~wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers, all from flip-flops except the constant-low request level
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin7_reg <= 1'b1;
         pin7_oe_reg <= 1'b0;
         sck_oe_reg <= 1'b0;
         sd_reg <= 1'b0;
         sd_oe_reg <= 1'b0;
         irq_oe_reg <= 1'b0;
      end else begin
         pin7_reg <= pin7_timer ? t1_out_reg : port_b_output_reg[7];
         pin7_oe_reg <= port_b_direction_reg[7] | auxiliary_control_reg[`VTS_ACR_T1_OUT_EN];
         sck_oe_reg <= mode_int;
         sd_reg <= peripheral_control_reg[5];
         sd_oe_reg <= (sr_mode == `VTS_SR_OFF) & (peripheral_control_reg[7:6] == 2'h3);
         irq_oe_reg <= irq_any;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign timer_output_pin_o = pin7_reg;
   assign timer_output_pin_oe_o = pin7_oe_reg;
   assign serial_clock_pin_o = sclk_reg;
   assign serial_clock_pin_oe_o = sck_oe_reg;
   assign serial_data_pin_o = sd_reg;
   assign serial_data_pin_oe_o = sd_oe_reg;
   assign irq_n_o = 1'b0;
   assign irq_n_oe_o = irq_oe_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence t1_wrap_s;
      t1_free && t1_timeout;
   endsequence
   sequence t2_fire_s;
      t2_set;
   endsequence

   t1_reload_a: assert property (t1_wrap_s |=> t1_cnt_reg == $past(t1_latch_reg))
      else $error("timer one did not reload from latch");
   t1_reflag_a: assert property (t1_wrap_s |=> ifr_reg[`VTS_IFR_T1] && (t1_out_reg != $past(t1_out_reg)))
      else $error("timer one free-run timeout missed flag or toggle");
   t1_retrigger_a: assert property (wr_t1ch |=> t1_cnt_reg == {$past(d), $past(t1_latch_reg[7:0])}
      && !ifr_reg[`VTS_IFR_T1])
      else $error("timer one high write did not restart");
   t1_latch_only_a: assert property ((wr_t1lh || wr_t1ll) && t1_cnt_reg != 16'h0000
      |=> t1_cnt_reg == $past(t1_cnt_reg) - 16'h0001)
      else $error("latch write disturbed countdown");
   pin7_select_a: assert property (pin7_timer && !$changed(auxiliary_control_reg)
      |=> timer_output_pin_o == $past(t1_out_reg))
      else $error("timer pin not following timer output");
   t2_oneshot_a: assert property (t2_fire_s ##1 !wr_t2ch |=> !t2_set)
      else $error("timer two flagged twice without reload");
   t2_pulse_hold_a: assert property (t2_pulse && !pc_fall && !wr_t2ch
      |=> t2_cnt_reg == $past(t2_cnt_reg))
      else $error("timer two counted without a pulse");
   sr_off_flag_a: assert property (sr_mode == `VTS_SR_OFF |=> !ifr_reg[`VTS_IFR_SR])
      else $error("shift flag set while shifter off");
   sr_stop_a: assert property (mode_int && last_bit && !sr_touch
      |=> sh_state_reg == vts_pkg::SH_IDLE && ifr_reg[`VTS_IFR_SR])
      else $error("shifter did not stop and flag after eight bits");
   irq_drive_a: assert property (irq_any |=> irq_n_oe_o)
      else $error("request line not pulled low");
   ier_set_a: assert property (wr_ier && d[`VTS_IER_SET] |=> (ier_reg & $past(d[6:0])) == $past(d[6:0]))
      else $error("enable set write lost bits");
endmodule : vts_timers_shifter
`default_nettype wire

// ===== rtl/vts_regs.svh
// Register indices, field positions and reset values of the timer and shifter block
`ifndef VTS_REGS_SVH
`define VTS_REGS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define VTS_IDX_PORT_B_OUTPUT 4'h0
`define VTS_IDX_PORT_B_DIRECTION 4'h2
`define VTS_IDX_T1_COUNT_LOW 4'h4
`define VTS_IDX_T1_COUNT_HIGH 4'h5
`define VTS_IDX_T1_LATCH_LOW 4'h6
`define VTS_IDX_T1_LATCH_HIGH 4'h7
`define VTS_IDX_T2_COUNT_LOW 4'h8
`define VTS_IDX_T2_COUNT_HIGH 4'h9
`define VTS_IDX_SERIAL_SHIFTER 4'ha
`define VTS_IDX_AUX_CONTROL 4'hb
`define VTS_IDX_PERIPH_CONTROL 4'hc
`define VTS_IDX_INT_FLAGS 4'hd
`define VTS_IDX_INT_ENABLES 4'he
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VTS_ACR_T1_OUT_EN 7
`define VTS_ACR_T1_FREE_RUN 6
`define VTS_ACR_T2_PULSE 5
`define VTS_ACR_SR_MSB 4
`define VTS_ACR_SR_LSB 2
`define VTS_IFR_ANY 7
`define VTS_IFR_T1 6
`define VTS_IFR_T2 5
`define VTS_IFR_SR 2
`define VTS_IER_SET 7
// ----------------------------------------------------------------
// Shift modes and reset values
// ----------------------------------------------------------------
`define VTS_SR_OFF 3'h0
`define VTS_SR_IN_T2 3'h1
`define VTS_SR_IN_SYS 3'h2
`define VTS_SR_IN_EXT 3'h3
`define VTS_RST_BYTE 8'h00
`define VTS_RST_WORD 16'h0000
`endif

// ===== rtl/vts_pkg.sv
// Types shared by the timer and shifter block
`default_nettype none
package vts_pkg;
   typedef logic [7:0] vts_byte_t;
   typedef enum logic {SH_IDLE, SH_RUN} vts_shift_state_t;
endpackage : vts_pkg
`default_nettype wire

// ===== bench/vts_peer.sv
// Far-side model: serial peripheral and pulse source for the timer and shifter block
`default_nettype none
module vts_peer (
   // Pins as seen from the far side
   input wire logic sclk_i,
   output logic ext_clk_o,
   output logic sdata_o,
   output logic pulse_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] frame_reg = 8'h00;
   int rises = 8;
   // Idle levels: clock high outside frames, pulse line high
   initial begin
      ext_clk_o = 1'b1;
      sdata_o = 1'b0;
      pulse_o = 1'b1;
   end
   // Next bit after each falling edge, so it is settled long before the rise
   always @(negedge sclk_i) begin
      if (rises > 0 && rises < 8) sdata_o = frame_reg[7 - rises];
      else if (rises >= 8) sdata_o = ~sdata_o; // Outside a frame no stale bit stays on the line
   end
   // Rising edges counted so a frame ends after eight bits
   always @(posedge sclk_i) begin
      if (rises < 8) rises++;
   end
   // Start a frame, most significant bit first, already on the line
   task automatic load(input logic [7:0] b);
      frame_reg = b;
      rises = 0;
      sdata_o = b[7];
   endtask : load
   // External shift clock of 160 ns; it runs only while a frame is sent
   task automatic clock_ext(input int cnt);
      #5; // Offset keeps both edges clear of the block's clock edges
      repeat (cnt) begin
         #80 ext_clk_o = 1'b0;
         #80 ext_clk_o = 1'b1;
      end
   endtask : clock_ext
   // Negative pulses held low across several clock edges
   task automatic pulse(input int cnt);
      repeat (cnt) begin
         #50 pulse_o = 1'b0;
         #60 pulse_o = 1'b1;
      end
   endtask : pulse
endmodule : vts_peer
`default_nettype wire

// ===== bench/vts_timers_shifter_test.sv
// Self-checking testbench of the timer and shifter block
`default_nettype none
`include "vts_regs.svh"
module vts_timers_shifter_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic we; logic [3:0] idx; logic [7:0] wd; logic [7:0] ex;} vts_row_t;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [7:0] wdat = 8'h00;
   logic [31:0] dat_o;
   logic ack, tpin, tpin_oe, sck_o, sck_oe, sd_o, sd_oe, irq_n, irq_oe, ext_clk, peer_sd, pulse;
   // Pin levels: whoever enables its driver owns the wire
   wire logic sclk_w = sck_oe ? sck_o : ext_clk;
   wire logic sdat_w = sd_oe ? sd_o : peer_sd;
   int err_count = 0;
   int cmp_count = 0;
   int edges = 0;
   int n = 0;
   logic [7:0] rv;
   vts_row_t rows [9] = '{
      '{1'b0, `VTS_IDX_INT_FLAGS, 8'h00, 8'h00}, '{1'b0, `VTS_IDX_INT_ENABLES, 8'h00, 8'h00},
      '{1'b1, `VTS_IDX_INT_ENABLES, 8'h85, 8'h00}, '{1'b0, `VTS_IDX_INT_ENABLES, 8'h00, 8'h05},
      '{1'b1, `VTS_IDX_INT_ENABLES, 8'h01, 8'h00}, '{1'b0, `VTS_IDX_INT_ENABLES, 8'h00, 8'h04},
      '{1'b1, `VTS_IDX_INT_ENABLES, 8'he0, 8'h00}, '{1'b0, `VTS_IDX_INT_ENABLES, 8'h00, 8'h64},
      '{1'b0, 4'hf, 8'h00, 8'h00}};
   vts_timers_shifter dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h000000, wdat}),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .pulse_count_pin_i(pulse), .timer_output_pin_o(tpin),
      .timer_output_pin_oe_o(tpin_oe), .serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sck_o),
      .serial_clock_pin_oe_o(sck_oe), .serial_data_pin_i(sdat_w), .serial_data_pin_o(sd_o),
      .serial_data_pin_oe_o(sd_oe), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));
   vts_peer peer_u (.sclk_i(sclk_w), .ext_clk_o(ext_clk), .sdata_o(peer_sd), .pulse_o(pulse));
   // 50 MHz clock, shift clock pulses counted, and a watchdog against hangs
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge sclk_w) edges++;
   initial begin
      #400000 err_count++;
      close_out();
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("compares=%0d mismatches=%0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask : idle
   // Classic cycle: request held until ack is sampled, then a cycle with the bus idle
   task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= i;
      wdat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (ack !== 1'b1) err_count++;
      if (ack !== 1'b1) close_out();
      rv = dat_o[7:0];
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : xfer
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      xfer(1'b1, i, d);
   endtask : wr
   task automatic rdc(input logic [3:0] i, input logic [7:0] e);
      xfer(1'b0, i, 8'h00);
      check(rv, e);
   endtask : rdc
   // Cycles until the timer pin changes; bounded so a dead timer cannot hang the run
   task automatic wait_pin();
      logic last;
      last = tpin;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (tpin === last && n < 5000);
      if (n >= 5000) close_out();
   endtask : wait_pin
   task automatic poll_sr();
      int k;
      k = 0;
      do begin
         xfer(1'b0, `VTS_IDX_INT_FLAGS, 8'h00);
         k++;
      end while (rv[2] !== 1'b1 && k < 60);
      check(rv, 8'h84);
   endtask : poll_sr
   // Shift in one byte on the block's own clock; the read at the end retriggers a frame
   task automatic frame(input logic [7:0] mode, input logic [7:0] b);
      wr(`VTS_IDX_AUX_CONTROL, mode);
      peer_u.load(b);
      edges = 0;
      xfer(1'b0, `VTS_IDX_SERIAL_SHIFTER, 8'h00);
      poll_sr();
      idle(10);
      check(8'(edges), 8'h08);
      rdc(`VTS_IDX_SERIAL_SHIFTER, b);
      idle(100);
   endtask : frame
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check({tpin_oe, irq_oe, sck_o, sd_oe, 3'h0, irq_n}, 8'h20);
      foreach (rows[i]) begin
         xfer(rows[i].we, rows[i].idx, rows[i].wd);
         if (!rows[i].we) check(rv, rows[i].ex);
      end
      $display("test register table done");
      // Free run from 0x0040: the pin toggles every 65 cycles
      wr(`VTS_IDX_PORT_B_DIRECTION, 8'h80);
      wr(`VTS_IDX_AUX_CONTROL, 8'hc0);
      wr(`VTS_IDX_T1_COUNT_LOW, 8'h40);
      wr(`VTS_IDX_T1_COUNT_HIGH, 8'h00);
      idle(2);
      wait_pin();
      rdc(`VTS_IDX_INT_FLAGS, 8'hc0);
      check({7'h0, irq_oe}, 8'h01);
      xfer(1'b0, `VTS_IDX_T1_COUNT_LOW, 8'h00);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      wait_pin();
      wait_pin();
      check(8'(n), 8'h41);
      wr(`VTS_IDX_PORT_B_DIRECTION, 8'h00);
      wr(`VTS_IDX_PORT_B_OUTPUT, 8'h80);
      idle(70);
      check({6'h0, tpin_oe, tpin}, 8'h03);
      wr(`VTS_IDX_PORT_B_DIRECTION, 8'h80);
      repeat (3) begin
         wr(`VTS_IDX_T1_COUNT_HIGH, 8'h00);
         idle(40);
         check({7'h0, tpin}, 8'h00);
      end
      wr(`VTS_IDX_T1_COUNT_HIGH, 8'h00);
      wr(`VTS_IDX_T1_LATCH_LOW, 8'h10);
      wr(`VTS_IDX_T1_LATCH_HIGH, 8'h00);
      wait_pin();
      check({7'h0, n > 30}, 8'h01);
      wait_pin();
      check(8'(n), 8'h11);
      wr(`VTS_IDX_AUX_CONTROL, 8'h00);
      wr(`VTS_IDX_INT_FLAGS, 8'h40);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      check({7'h0, irq_oe}, 8'h00);
      $display("test timer one done");
      // One-shot timer two from 8
      wr(`VTS_IDX_T2_COUNT_LOW, 8'h08);
      wr(`VTS_IDX_T2_COUNT_HIGH, 8'h00);
      idle(12);
      rdc(`VTS_IDX_INT_FLAGS, 8'ha0);
      wr(`VTS_IDX_T2_COUNT_HIGH, 8'h00);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      idle(12);
      rdc(`VTS_IDX_INT_FLAGS, 8'ha0);
      xfer(1'b0, `VTS_IDX_T2_COUNT_LOW, 8'h00);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      idle(40);
      rdc(`VTS_IDX_T2_COUNT_HIGH, 8'hff);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      // Pulse counting from 2: the flag comes with the third pulse
      wr(`VTS_IDX_AUX_CONTROL, 8'h20);
      wr(`VTS_IDX_T2_COUNT_LOW, 8'h02);
      wr(`VTS_IDX_T2_COUNT_HIGH, 8'h00);
      for (int p = 0; p < 3; p++) begin
         peer_u.pulse(1);
         idle(4);
         rdc(`VTS_IDX_INT_FLAGS, (p == 2) ? 8'ha0 : 8'h00);
      end
      wr(`VTS_IDX_INT_FLAGS, 8'h20);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      peer_u.pulse(3);
      idle(4);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      $display("test timer two done");
      // Shifter off, then shift-in at system rate, timer pace and external clock
      wr(`VTS_IDX_AUX_CONTROL, 8'h00);
      wr(`VTS_IDX_SERIAL_SHIFTER, 8'h5a);
      idle(30);
      rdc(`VTS_IDX_SERIAL_SHIFTER, 8'h5a);
      rdc(`VTS_IDX_INT_FLAGS, 8'h00);
      wr(`VTS_IDX_PERIPH_CONTROL, 8'he0);
      idle(2);
      check({6'h0, sd_oe, sd_o}, 8'h03);
      wr(`VTS_IDX_PERIPH_CONTROL, 8'h00);
      frame(8'h08, 8'ha5);
      wr(`VTS_IDX_T2_COUNT_LOW, 8'h03);
      frame(8'h04, 8'h3c);
      wr(`VTS_IDX_AUX_CONTROL, 8'h0c);
      xfer(1'b0, `VTS_IDX_SERIAL_SHIFTER, 8'h00);
      foreach (rows[i]) begin
         if (i > 1) break;
         peer_u.load((i == 0) ? 8'hc3 : 8'h96);
         peer_u.clock_ext(4);
         idle(4);
         rdc(`VTS_IDX_INT_FLAGS, 8'h00);
         peer_u.clock_ext(4);
         idle(4);
         rdc(`VTS_IDX_INT_FLAGS, 8'h84);
         rdc(`VTS_IDX_SERIAL_SHIFTER, (i == 0) ? 8'hc3 : 8'h96);
      end
      $display("test shifter done");
      rst_i <= 1'b1;
      idle(2);
      rst_i <= 1'b0;
      idle(1);
      rdc(`VTS_IDX_INT_ENABLES, 8'h00);
      check({tpin_oe, irq_oe, sck_o, sd_oe, 4'h0}, 8'h20);
      $display("test second reset done");
      close_out();
   end
endmodule : vts_timers_shifter_test
`default_nettype wire
